// ### src/pwt_pkg.sv
// Package with register map, field positions, reset values and timing constants.
package pwt_pkg;
    // Printed offsets are not all multiples of four, so they are word indices.
    localparam logic [5:0] IDX_CTRL = 6'h14;
    localparam logic [5:0] IDX_RATE_HIGH = 6'h16;
    localparam logic [5:0] IDX_RATE_LOW = 6'h15;
    localparam logic [5:0] IDX_TEST3 = 6'h17;
    localparam logic [5:0] IDX_TRIM_HIGH = 6'h18;
    localparam logic [5:0] IDX_TRIM_LOW = 6'h19;
    localparam logic [5:0] IDX_HOT_TRIM = 6'h1A;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h1B;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h1C;
    localparam logic [5:0] IDX_CLK_STATUS = 6'h1D;

    // Control register field positions.
    localparam int CTRL_CLK_SEL_BIT = 7;
    localparam int CTRL_FEATURE_EN_BIT = 2;
    localparam int CTRL_IRQ_EN_BIT = 1;
    localparam int CTRL_FLAG_BIT = 0;

    // Hot sense trim fields.
    localparam int HOT_OFFSET_EN_BIT = 7;

    // Clock status register bit positions.
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_OSC_UP_BIT = 0;

    // Interrupt status and mask bit position.
    localparam int IRQ_TIMEOUT_BIT = 0;

    // Reset values.
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] HOT_TRIM_RESET = 8'h00;
    localparam logic [7:0] TEST3_RESET = 8'h00;
    localparam logic [15:0] TRIM_RESET = 16'hF8FF;
    localparam logic [15:0] TRIM_MASK = 16'hFBFF;

    // Autonomous clock: a 20 kHz oscillator is modelled by an enable from a divider.
    localparam int CLK_HZ = 200_000_000;
    localparam int ACLK_HZ = 20_000;
    localparam int ACLK_DIV_CYCLES = CLK_HZ / ACLK_HZ;
    localparam logic [15:0] ACLK_DIV_LAST = 16'(ACLK_DIV_CYCLES - 1);
    // Two autonomous clock periods make one autonomous timer tick.
    localparam logic [0:0] ACLK_PER_TICK_LAST = 1'h1;
    // Gate release latency in autonomous clock cycles before the first tick.
    localparam logic [1:0] GATE_RELEASE_ACLK = 2'h3;
endpackage

// ### src/pwt_top.sv
// Periodic wakeup timer with oscillator, hot sense and factory trim registers.
//
// Behaviour
// R01 - Rate register writes take effect only while the periodic feature is disabled.
// R02 - Sixteen-bit rate in high and low bytes, low byte at 0x15, reset zero.
// R03 - Autonomous clock: period is 2*(rate+1) times two autonomous clock periods.
// R04 - Bus clock: period is 2*(rate+1) bus clock cycles.
// R05 - First autonomous timeout after enable adds two to three autonomous cycles.
// R06 - Factory test register always readable, writable only in special mode.
// R07 - Hot offset applies only when trim bit 7 is set, else ignored.
// R08 - Hot trim bits 3 to 0 form a binary-weighted offset selector.
// R09 - Oscillator trim writes ignored while protection bit is set; reads always allowed.
// R10 - Trim writes while loop clock selected clear lock and oscillator-up status.
// R11 - After reset release the factory trim value loads into the trim registers.
// R12 - Temperature coefficient trim in bits 15-11; codes 0 and 16 disable it.
// R13 - Frequency trim in bits 9-0: upper four coarse, lower six fine.
// R14 - Timeout sets sticky flag, cleared by writing one, raises interrupt if enabled.
// R15 - Clock select zero picks autonomous clock, one picks bus clock.
// R16 - Feature enable starts the periodic timer; clearing it stops the timer.
// R17 - Counter restarts from zero after each timeout while enabled.
module pwt_top (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic special_mode_i,
    input wire logic write_protect_bit_i,
    input wire logic loop_clock_select_i,
    input wire logic lock_set_i,
    input wire logic osc_up_set_i,
    input wire logic [15:0] factory_trim_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    output logic timeout_pulse_o,
    output logic [3:0] hot_offset_o,
    output logic [4:0] temp_coeff_trim_o,
    output logic tc_comp_enable_o,
    output logic [3:0] osc_coarse_trim_o,
    output logic [5:0] osc_fine_trim_o
);
    import pwt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers for pins from outside the core clock domain.

    logic [1:0] special_sync_q;
    logic [1:0] protect_sync_q;
    logic [1:0] plls_sync_q;
    logic [1:0] lock_sync_q;
    logic [1:0] oscup_sync_q;
    // The edge detectors start low, so a status pin already high at reset release
    // still sets its bit once, as soon as the synchroniser has filled.
    logic lock_prev_q;
    logic oscup_prev_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            special_sync_q <= 2'h0;
            protect_sync_q <= 2'h0;
            plls_sync_q <= 2'h0;
            lock_sync_q <= 2'h0;
            oscup_sync_q <= 2'h0;
            lock_prev_q <= 1'h0;
            oscup_prev_q <= 1'h0;
        end else begin
            special_sync_q <= {special_sync_q[0], special_mode_i};
            protect_sync_q <= {protect_sync_q[0], write_protect_bit_i};
            plls_sync_q <= {plls_sync_q[0], loop_clock_select_i};
            lock_sync_q <= {lock_sync_q[0], lock_set_i};
            oscup_sync_q <= {oscup_sync_q[0], osc_up_set_i};
            lock_prev_q <= lock_sync_q[1];
            oscup_prev_q <= oscup_sync_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus access decode. Each access is answered one cycle after it is seen.

    logic access_q;
    logic wr_now;
    logic rd_now;
    logic [5:0] idx;
    logic be0;

    assign idx = avs_address_i[7:2];
    // Only the lowest byte lane carries register data, so only its enable gates a write.
    assign be0 = avs_byteenable_i[0];
    // A write commits on the edge at which the master sees waitrequest low, the only
    // edge at which the request is known to be complete; reads are launched a cycle
    // earlier so that their data stand in that same cycle.
    assign wr_now = avs_write_i && access_q && be0;
    assign rd_now = avs_read_i && !access_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            access_q <= 1'h0;
            avs_waitrequest_o <= 1'h1;
        end else begin
            access_q <= (avs_read_i || avs_write_i) && !access_q;
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !access_q);
        end
    end

    function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
        hit = (a == r);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Control register and rate registers.

    logic [7:0] ctrl_q;
    logic [7:0] rate_high_q;
    logic [7:0] rate_low_q;
    logic feature_en;
    logic clk_sel;
    logic timeout_evt;

    assign feature_en = ctrl_q[CTRL_FEATURE_EN_BIT];
    assign clk_sel = ctrl_q[CTRL_CLK_SEL_BIT];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            if (wr_now && hit(idx, IDX_CTRL)) begin
                ctrl_q[CTRL_FEATURE_EN_BIT] <= avs_writedata_i[CTRL_FEATURE_EN_BIT]; // [R16]
                ctrl_q[CTRL_IRQ_EN_BIT] <= avs_writedata_i[CTRL_IRQ_EN_BIT];
                // The clock source is frozen while running; the enabling write still sets it, the disabling write does not.
                if (!feature_en) begin
                    ctrl_q[CTRL_CLK_SEL_BIT] <= avs_writedata_i[CTRL_CLK_SEL_BIT]; // [R15]
                end
            end
            // Writing zero to the flag has no effect; only a one clears it.
            // Set wins over a write-one clear in the same cycle.
            if (timeout_evt) begin
                ctrl_q[CTRL_FLAG_BIT] <= 1'h1; // [R14]
            end else if (wr_now && hit(idx, IDX_CTRL) && avs_writedata_i[CTRL_FLAG_BIT]) begin
                ctrl_q[CTRL_FLAG_BIT] <= 1'h0; // [R14]
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rate_high_q <= RATE_RESET; // [R02]
            rate_low_q <= RATE_RESET; // [R02]
        end else if (wr_now && !feature_en) begin // [R01]
            // Both bytes freeze while running, so the count never compares against
            // a period built from one old byte and one new byte.
            if (hit(idx, IDX_RATE_HIGH)) begin
                rate_high_q <= avs_writedata_i[7:0];
            end
            if (hit(idx, IDX_RATE_LOW)) begin
                rate_low_q <= avs_writedata_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Autonomous clock enable and periodic counter.

    logic [15:0] aclk_div_q;
    logic aclk_en;
    logic aclk_half_q;
    logic [1:0] gate_q;
    logic tick;
    logic [16:0] cnt_q;
    logic [16:0] cnt_last;

    assign aclk_en = (aclk_div_q == ACLK_DIV_LAST);
    // The counter counts ticks; the period is 2*(rate+1) ticks.
    assign cnt_last = {rate_high_q, rate_low_q, 1'h1}; // [R03] [R04]
    assign tick = clk_sel ? 1'h1 : (aclk_en && aclk_half_q == ACLK_PER_TICK_LAST
                                    && gate_q == GATE_RELEASE_ACLK); // [R15] [R03]
    assign timeout_evt = feature_en && tick && (cnt_q == cnt_last);

    // The divider runs free from reset, so where an enable falls within an
    // autonomous period is not fixed; that is the spread of the first timeout.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aclk_div_q <= 16'h0000;
        end else if (aclk_en) begin
            aclk_div_q <= 16'h0000;
        end else begin
            aclk_div_q <= aclk_div_q + 16'h0001;
        end
    end

    // Gate release: after an enable, three autonomous clock enables pass before the
    // count starts, the first of them partial, so the first timeout comes two to three
    // autonomous periods late.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_q <= 2'h0;
            aclk_half_q <= 1'h0;
        end else if (!feature_en || clk_sel) begin
            gate_q <= 2'h0;
            aclk_half_q <= 1'h0;
        end else if (aclk_en) begin
            if (gate_q != GATE_RELEASE_ACLK) begin
                gate_q <= gate_q + 2'h1; // [R05]
            end else begin
                aclk_half_q <= ~aclk_half_q;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 17'h00000;
        end else if (!feature_en) begin
            // Disabling clears the count so the next enable starts a full period.
            cnt_q <= 17'h00000; // [R16]
        end else if (tick) begin
            if (cnt_q == cnt_last) begin
                cnt_q <= 17'h00000; // [R17]
            end else begin
                cnt_q <= cnt_q + 17'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trim registers and factory test register.

    logic [7:0] test3_q;
    logic [7:0] hot_trim_q;
    logic [15:0] trim_q;
    logic load_pend_q;
    logic trim_wr;

    // The protection pin passes its synchroniser first, so a write within two cycles
    // of the pin rising can still land; software should settle the pin beforehand.
    assign trim_wr = wr_now && !protect_sync_q[1]
                     && (hit(idx, IDX_TRIM_HIGH) || hit(idx, IDX_TRIM_LOW)); // [R09]

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            test3_q <= TEST3_RESET;
            hot_trim_q <= HOT_TRIM_RESET;
        end else if (wr_now) begin
            if (hit(idx, IDX_TEST3) && special_sync_q[1]) begin
                test3_q <= avs_writedata_i[7:0]; // [R06]
            end
            if (hit(idx, IDX_HOT_TRIM)) begin
                hot_trim_q <= avs_writedata_i[7:0] & 8'h8F;
            end
        end
    end

    // The factory value is sampled by a clocked load just after reset release.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trim_q <= TRIM_RESET;
            load_pend_q <= 1'h1;
        end else if (load_pend_q) begin
            trim_q <= factory_trim_i & TRIM_MASK; // [R11]
            load_pend_q <= 1'h0;
        end else if (trim_wr) begin
            if (hit(idx, IDX_TRIM_HIGH)) begin
                trim_q[15:8] <= avs_writedata_i[7:0] & TRIM_MASK[15:8]; // [R12] [R13]
            end else begin
                trim_q[7:0] <= avs_writedata_i[7:0]; // [R13]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock status bits cleared by trim writes under loop clock selection.

    logic [7:0] clk_stat_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_stat_q <= 8'h00;
        end else begin
            // A fresh rising status edge wins over the clearing write.
            if (lock_sync_q[1] && !lock_prev_q) begin
                clk_stat_q[STAT_LOCK_BIT] <= 1'h1;
            end else if (trim_wr && plls_sync_q[1]) begin
                clk_stat_q[STAT_LOCK_BIT] <= 1'h0; // [R10]
            end
            if (oscup_sync_q[1] && !oscup_prev_q) begin
                clk_stat_q[STAT_OSC_UP_BIT] <= 1'h1;
            end else if (trim_wr && plls_sync_q[1]) begin
                clk_stat_q[STAT_OSC_UP_BIT] <= 1'h0; // [R10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask.

    logic [7:0] irq_stat_q;
    logic [7:0] irq_mask_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_q <= 8'h00;
            irq_mask_q <= 8'h00;
        end else begin
            if (wr_now && hit(idx, IDX_IRQ_MASK)) begin
                // Only the timeout bit exists; the other mask bits read as zero.
                irq_mask_q <= avs_writedata_i[7:0] & 8'h01;
            end
            if (timeout_evt) begin
                irq_stat_q[IRQ_TIMEOUT_BIT] <= 1'h1;
            end else if (wr_now && hit(idx, IDX_IRQ_STATUS)
                         && avs_writedata_i[IRQ_TIMEOUT_BIT]) begin
                irq_stat_q[IRQ_TIMEOUT_BIT] <= 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs and read data.

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'h0;
            timeout_pulse_o <= 1'h0;
            hot_offset_o <= 4'h0;
            temp_coeff_trim_o <= 5'h00;
            tc_comp_enable_o <= 1'h0;
            osc_coarse_trim_o <= 4'h0;
            osc_fine_trim_o <= 6'h00;
        end else begin
            // Either the flag with its enable or the status register with its mask.
            irq_o <= (ctrl_q[CTRL_FLAG_BIT] && ctrl_q[CTRL_IRQ_EN_BIT])
                     || |(irq_stat_q & irq_mask_q); // [R14]
            timeout_pulse_o <= timeout_evt;
            hot_offset_o <= hot_trim_q[HOT_OFFSET_EN_BIT] ? hot_trim_q[3:0] : 4'h0; // [R07] [R08]
            temp_coeff_trim_o <= trim_q[15:11];
            // Codes 00000 and 10000 both switch compensation off, so the top bit is ignored.
            tc_comp_enable_o <= (trim_q[14:11] != 4'h0); // [R12]
            osc_coarse_trim_o <= trim_q[9:6]; // [R13]
            osc_fine_trim_o <= trim_q[5:0]; // [R13]
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (rd_now) begin
            if (hit(idx, IDX_CTRL)) begin
                avs_readdata_o <= {24'h000000, ctrl_q};
            end else if (hit(idx, IDX_RATE_HIGH)) begin
                avs_readdata_o <= {24'h000000, rate_high_q};
            end else if (hit(idx, IDX_RATE_LOW)) begin
                avs_readdata_o <= {24'h000000, rate_low_q};
            end else if (hit(idx, IDX_TEST3)) begin
                avs_readdata_o <= {24'h000000, test3_q}; // [R06]
            end else if (hit(idx, IDX_TRIM_HIGH)) begin
                avs_readdata_o <= {24'h000000, trim_q[15:8]};
            end else if (hit(idx, IDX_TRIM_LOW)) begin
                avs_readdata_o <= {24'h000000, trim_q[7:0]};
            end else if (hit(idx, IDX_HOT_TRIM)) begin
                avs_readdata_o <= {24'h000000, hot_trim_q};
            end else if (hit(idx, IDX_IRQ_STATUS)) begin
                avs_readdata_o <= {24'h000000, irq_stat_q};
            end else if (hit(idx, IDX_IRQ_MASK)) begin
                avs_readdata_o <= {24'h000000, irq_mask_q};
            end else if (hit(idx, IDX_CLK_STATUS)) begin
                avs_readdata_o <= {24'h000000, clk_stat_q};
            end else begin
                // Unmapped offsets read as zero, so software may probe the map safely.
                avs_readdata_o <= 32'h00000000;
            end
        end
    end
endmodule

// ### verif/pwt_top_properties.sv
// Concurrent checks on the bus handshake, timer pulse and trim outputs.
module pwt_top_properties (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic irq_o,
    input wire logic timeout_pulse_o,
    input wire logic [3:0] hot_offset_o,
    input wire logic [4:0] temp_coeff_trim_o,
    input wire logic tc_comp_enable_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_ACK_NEXT: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("access not answered one cycle after request");
    AST_ACK_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    AST_ACK_REQ: assert property (!avs_waitrequest_o |-> (avs_read_i || avs_write_i))
        else $error("answer without a pending request");
    AST_RD_HOLD: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
        else $error("read data changed without a read");
    AST_PULSE_ONE: assert property (timeout_pulse_o |=> !timeout_pulse_o)
        else $error("timeout pulse longer than one cycle");
    AST_TC_OFF: assert property (tc_comp_enable_o == (temp_coeff_trim_o[3:0] != 4'h0))
        else $error("compensation enable disagrees with coefficient code");
    AST_HOT_WRITE: assert property ($changed(hot_offset_o)
        |-> ($past(avs_write_i) || $past(avs_write_i, 2)))
        else $error("hot offset changed without a write");
    AST_IRQ_CLEAR: assert property ($fell(irq_o)
        |-> ($past(avs_write_i) || $past(avs_write_i, 2)))
        else $error("interrupt dropped without a clearing write");
endmodule

bind pwt_top pwt_top_properties u_props (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o),
    .timeout_pulse_o(timeout_pulse_o),
    .hot_offset_o(hot_offset_o),
    .temp_coeff_trim_o(temp_coeff_trim_o),
    .tc_comp_enable_o(tc_comp_enable_o)
);

// ### verif/pwt_top_tb.sv
// Self-checking bench for the periodic wakeup timer and trim registers.
module pwt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pwt_pkg::*;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic special_mode_i = 1'b0, write_protect_bit_i = 1'b0, loop_clock_select_i = 1'b0;
    logic lock_set_i = 1'b0, osc_up_set_i = 1'b0;
    logic [15:0] factory_trim_i = 16'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, irq_o, timeout_pulse_o, tc_comp_enable_o;
    logic [3:0] hot_offset_o, osc_coarse_trim_o;
    logic [4:0] temp_coeff_trim_o;
    logic [5:0] osc_fine_trim_o;
    int err_total = 0, checks = 0, seed = 29210, n;
    logic [31:0] exp_q[$];
    string nm_q[$];
    logic [15:0] rate;

    pwt_top DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .special_mode_i(special_mode_i),
        .write_protect_bit_i(write_protect_bit_i), .loop_clock_select_i(loop_clock_select_i),
        .lock_set_i(lock_set_i), .osc_up_set_i(osc_up_set_i), .factory_trim_i(factory_trim_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
        .timeout_pulse_o(timeout_pulse_o), .hot_offset_o(hot_offset_o),
        .temp_coeff_trim_o(temp_coeff_trim_o), .tc_comp_enable_o(tc_comp_enable_o),
        .osc_coarse_trim_o(osc_coarse_trim_o), .osc_fine_trim_o(osc_fine_trim_o));

    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Each access leaves one idle edge first, so the request is never raised twice in a step.
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge core_clk_i);
        avs_address_i <= {idx, 2'h0};
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 50);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (k >= 50) begin
            err_total++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] e, input string what);
        exp_q.push_back({24'h0, e});
        nm_q.push_back(what);
        bus(1'b0, idx, 8'h00);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge core_clk_i);
    endtask

    task automatic wait_pulse(input int lim, output int k);
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (timeout_pulse_o !== 1'b1 && k < lim);
        if (k >= lim) begin
            err_total++;
            print_verdict();
        end
    endtask

    // Read results are compared here, oldest expectation first.
    always @(posedge core_clk_i) begin
        if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
            check(nm_q.pop_front(), avs_readdata_o, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        err_total++;
        print_verdict();
    end

    initial begin
        factory_trim_i <= 16'($random(seed));
        settle(6);
        rst_n_i <= 1'b1;
        settle(4);
        rd(IDX_RATE_LOW, RATE_RESET, "rate_low");
        rd(IDX_RATE_HIGH, RATE_RESET, "rate_high");
        rd(IDX_TRIM_HIGH, factory_trim_i[15:8] & 8'hFB, "trim_high");
        rd(IDX_TRIM_LOW, factory_trim_i[7:0], "trim_low");
        check("coeff", 32'(temp_coeff_trim_o), 32'(factory_trim_i[15:11]));
        check("coarse", 32'(osc_coarse_trim_o), 32'(factory_trim_i[9:6]));
        check("fine", 32'(osc_fine_trim_o), 32'(factory_trim_i[5:0]));
        rd(6'h3F, 8'h00, "unmapped");
        wr(IDX_HOT_TRIM, 8'h0A);
        settle(2);
        check("hot_off", 32'(hot_offset_o), 32'h0);
        for (int b = 0; b < 4; b++) begin
            wr(IDX_HOT_TRIM, 8'h80 | (8'h01 << b));
            settle(2);
            check("hot_on", 32'(hot_offset_o), 32'h1 << b);
        end
        wr(IDX_TEST3, 8'h5A);
        rd(IDX_TEST3, TEST3_RESET, "test3_locked");
        special_mode_i <= 1'b1;
        settle(4);
        wr(IDX_TEST3, 8'h5A);
        rd(IDX_TEST3, 8'h5A, "test3_special");
        write_protect_bit_i <= 1'b1;
        lock_set_i <= 1'b1;
        osc_up_set_i <= 1'b1;
        settle(4);
        wr(IDX_TRIM_LOW, 8'h3C);
        rd(IDX_TRIM_LOW, factory_trim_i[7:0], "trim_protected");
        write_protect_bit_i <= 1'b0;
        settle(4);
        wr(IDX_TRIM_LOW, 8'h3C);
        wr(IDX_TRIM_HIGH, 8'hFF);
        rd(IDX_TRIM_HIGH, 8'hFB, "trim_high_rw");
        rd(IDX_CLK_STATUS, 8'h03, "status_kept");
        settle(2);
        check("fine_w", 32'(osc_fine_trim_o), 32'h3C);
        check("coarse_w", 32'(osc_coarse_trim_o), 32'hC);
        wr(IDX_TRIM_HIGH, 8'h80);
        settle(2);
        check("tc_off", {31'h0, tc_comp_enable_o}, 32'h0);
        loop_clock_select_i <= 1'b1;
        settle(4);
        wr(IDX_TRIM_HIGH, 8'h08);
        rd(IDX_CLK_STATUS, 8'h00, "status_cleared");
        settle(2);
        check("tc_on", {31'h0, tc_comp_enable_o}, 32'h1);
        wr(IDX_CTRL, 8'h80);
        for (int i = 0; i < 2; i++) begin
            rate = (i == 0) ? 16'h0003 : {8'h01, 4'h0, 4'($random(seed))};
            wr(IDX_RATE_LOW, rate[7:0]);
            wr(IDX_RATE_HIGH, rate[15:8]);
            wr(IDX_CTRL, 8'h86);
            wr(IDX_RATE_LOW, ~rate[7:0]);
            rd(IDX_RATE_LOW, rate[7:0], "rate_locked");
            wait_pulse(2000, n);
            wait_pulse(2000, n);
            check("period", n, 2 * (rate + 1));
            wait_pulse(2000, n);
            check("period_again", n, 2 * (rate + 1));
            check("irq", {31'h0, irq_o}, 32'h1);
            wr(IDX_CTRL, 8'h81);
            wr(IDX_CTRL, 8'h81);
            settle(2);
            check("irq_clear", {31'h0, irq_o}, 32'h0);
        end
        wr(IDX_IRQ_MASK, 8'h01);
        settle(2);
        check("irq_mask", {31'h0, irq_o}, 32'h1);
        wr(IDX_IRQ_STATUS, 8'h01);
        settle(2);
        check("irq_status", {31'h0, irq_o}, 32'h0);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_RATE_LOW, 8'h00);
        wr(IDX_RATE_HIGH, 8'h00);
        wr(IDX_CTRL, 8'h04);
        n = 0;
        repeat (2000) begin
            @(posedge core_clk_i);
            n += int'(timeout_pulse_o === 1'b1);
        end
        check("aclk_slow", n, 0);
        // Rate zero gives four autonomous periods, plus two to three for the gate release.
        wait_pulse(70000, n);
        check("aclk_lo", {31'h0, n + 2000 >= 6 * ACLK_DIV_CYCLES}, 32'h1);
        check("aclk_hi", {31'h0, n + 2000 <= 7 * ACLK_DIV_CYCLES + 2}, 32'h1);
        wr(IDX_CTRL, 8'h00);
        print_verdict();
    end
endmodule
